// [common/bdr_pkg.sv]
// Purpose: shared constants and types for the debug register set
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   register index equals the offset seen by debug commands

package bdr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS   = 4'h1;
    localparam logic [3:0] ADDR_CCR      = 4'h6;
    localparam logic [3:0] ADDR_POSITION = 4'h7;

    // ------------------------------------------------------------
    // status register field positions
    // ------------------------------------------------------------
    localparam int ST_ENABLE = 7;
    localparam int ST_ACTIVE = 6;
    localparam int ST_TAG    = 5;
    localparam int ST_SDV    = 4;
    localparam int ST_TRACE  = 3;
    localparam int ST_CLKSEL = 2;
    localparam int ST_UNSECURED_FLAG  = 1;

    // position register: bits 6..3 carry block position bits 14..11
    localparam int POS_LSB = 3;
    localparam int POS_W   = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CCR_RST  = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // command carrier
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_HW,       // hardware debug command
        SRC_FW,       // standard firmware write command
        SRC_FW_EXIT,  // timed exit store of standard firmware
        SRC_OTHER     // any other store, e.g. user code
    } bdr_src_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        bdr_src_t   src;
        logic [3:0] addr;
        logic [7:0] data;
    } bdr_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bdr_rsp_t;

    // true for the two command paths allowed to write status fields; the timed exit store can only clear active and shift-valid
    function automatic logic is_debug_cmd(input bdr_src_t src);
        is_debug_cmd = (src == SRC_HW) || (src == SRC_FW);
    endfunction : is_debug_cmd

endpackage : bdr_pkg

// [design/bdr_ccr_hold.sv]
// Purpose: 8-bit holding register for the processor condition codes
// Assumes: write and capture never matter in the same cycle
// Notes:   a debug write wins over capture

`timescale 1ns/100ps

module bdr_ccr_hold (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // update sources
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       capture_in,
    input  wire logic [7:0] core_ccr_in,
    // held value
    output logic      [7:0] ccr_out
);

    // all eight bits implemented, no reserved positions
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ccr_out <= bdr_pkg::CCR_RST;
        end else if (wr_en_in) begin
            ccr_out <= wr_data_in;
        end else if (capture_in) begin
            ccr_out <= core_ccr_in;
        end
    end

endmodule : bdr_ccr_hold

// [design/bdr_boot_seq.sv]
// Purpose: post-reset sequence that stands in for the secure and standard firmware
// Assumes: mode and security inputs are stable from reset release
// Notes:   only acts in special single-chip mode

`timescale 1ns/100ps

module bdr_boot_seq (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // mode and security
    input  wire logic special_single_chip_in,
    input  wire logic secured_in,
    input  wire logic erase_done_in,
    input  wire logic erase_ok_in,
    // results
    output logic      enable_set_out,
    output logic      unsecured_flag_set_out,
    output logic      secure_table_map_out
);

    typedef enum logic [1:0] {B_START, B_VERIFY, B_DONE} bdr_boot_t;
    bdr_boot_t state_q;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= B_START;
        end else begin
            unique case (state_q)
                B_START:  state_q <= (special_single_chip_in && secured_in) ? B_VERIFY : B_DONE;
                B_VERIFY: if (erase_done_in) state_q <= B_DONE;
                B_DONE:   state_q <= B_DONE;
            endcase
        end
    end

    // unsecured: enable at once; secured: only after a passing erase test
    assign enable_set_out = special_single_chip_in &&
                            ((state_q == B_START && !secured_in) ||
                             (state_q == B_VERIFY && erase_done_in && erase_ok_in));
    assign unsecured_flag_set_out  = state_q == B_VERIFY && erase_done_in && erase_ok_in;
    assign secure_table_map_out = state_q == B_VERIFY;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_secure_waits;
        secured_in && state_q == B_VERIFY && !erase_done_in |-> !enable_set_out;
    endproperty
    a_secure_waits: assert property (p_secure_waits) else $error("enable set before erase test");

    property p_unsecured_flag_cause;
        unsecured_flag_set_out |-> special_single_chip_in && secured_in && erase_ok_in && enable_set_out;
    endproperty
    a_unsecured_flag_cause: assert property (p_unsecured_flag_cause) else $error("unsecure set without erased part");

endmodule : bdr_boot_seq

// [design/bdr_debug_regs.sv]
// Purpose: status, condition-code hold and block position registers of the debug unit
// Assumes: commands arrive already decoded from the single-wire link, one per cycle
// Notes:   read data answer one cycle after the read command
//
// Behaviour
// - with debug enable clear the unit refuses to go active but still serves hardware commands.
// - the active bit is set only by the hardware on debug entry, never by a write.
// - while active the standard firmware table is mapped into memory.
// - the active bit is cleared only by the firmware's timed exit store, which unmaps the table.
// - the clock-select bit changes only by hardware or firmware debug writes.
// - in special single-chip mode enable is set right after reset, or after a passing erase verify if secured.
// - an unsecured, fully erased part in special single-chip mode reads enable as one.
// - the unsecure bit reads one only for a secured, fully erased part in special single-chip mode.
// - the status register is readable and writable in every mode, bit limits aside.
// - an eight-bit read/write condition-code hold register is provided.
// - offset seven reads block position bits 14 to 11 in bits 6 to 3, other bits zero.
// - all registers are reached only through debug read and write commands.

`timescale 1ns/100ps

module bdr_debug_regs (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // debug command port
    input  wire bdr_pkg::bdr_cmd_t cmd_in,
    output bdr_pkg::bdr_rsp_t      rsp_out,
    // debug entry
    input  wire logic              entry_req_in,
    output logic                   entry_refused_out,
    // mode and security
    input  wire logic              special_single_chip_in,
    input  wire logic              secured_in,
    input  wire logic              erase_done_in,
    input  wire logic              erase_ok_in,
    // core side
    input  wire logic [3:0]        reg_block_pos_in,
    input  wire logic [7:0]        core_ccr_in,
    // status to the rest of the chip
    output logic                   debug_enable_out,
    output logic                   debug_active_out,
    output logic                   fw_table_map_out,
    output logic                   secure_table_map_out,
    output logic                   debug_clock_select_out,
    output logic                   tag_enable_out,
    output logic                   shift_data_valid_out,
    output logic                   trace_out,
    output logic                   unsecured_flag_out,
    output logic [7:0]             ccr_hold_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic       enable_q;
    logic       active_q;
    logic       tag_q;
    logic       sdv_q;
    logic       trace_q;
    logic       clksel_q;
    logic       unsecured_flag_q;
    logic       boot_enter_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    logic       boot_enable_set;
    logic       boot_unsecured_flag_set;
    logic       wr_status;
    logic       wr_status_dbg;
    logic       wr_exit;
    logic       wr_ccr;
    logic       rd_cmd;
    logic       entry_try;
    logic       entry_ok;
    logic       exit_ok;
    logic [7:0] status_img;
    logic [7:0] position_img;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // registers are reached only by commands on this port
    assign wr_status     = cmd_in.valid && cmd_in.write && cmd_in.addr == bdr_pkg::ADDR_STATUS;
    assign wr_status_dbg = wr_status && bdr_pkg::is_debug_cmd(cmd_in.src);
    assign wr_exit       = wr_status && cmd_in.src == bdr_pkg::SRC_FW_EXIT;
    assign wr_ccr        = cmd_in.valid && cmd_in.write && cmd_in.addr == bdr_pkg::ADDR_CCR &&
                           bdr_pkg::is_debug_cmd(cmd_in.src);
    assign rd_cmd        = cmd_in.valid && !cmd_in.write;

    // ------------------------------------------------------------
    // firmware stand-in after reset
    // ------------------------------------------------------------
    bdr_boot_seq u_boot (
        .clk_in                 (clk_in),
        .sys_rst_in             (sys_rst_in),
        .special_single_chip_in (special_single_chip_in),
        .secured_in             (secured_in),
        .erase_done_in          (erase_done_in),
        .erase_ok_in            (erase_ok_in),
        .enable_set_out         (boot_enable_set),
        .unsecured_flag_set_out          (boot_unsecured_flag_set),
        .secure_table_map_out   (secure_table_map_out)
    );

    // special single-chip mode goes active out of reset once enabled
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            boot_enter_q <= 1'b0;
        end else begin
            boot_enter_q <= boot_enable_set;
        end
    end

    // ------------------------------------------------------------
    // entry and exit
    // ------------------------------------------------------------
    assign entry_try = entry_req_in || boot_enter_q;
    assign entry_ok  = entry_try && enable_q && !active_q;
    // refused only the entry; commands on the port keep working
    assign entry_refused_out = entry_try && !enable_q && !active_q;
    assign exit_ok   = wr_exit && !cmd_in.data[bdr_pkg::ST_ACTIVE] && active_q;

    // ------------------------------------------------------------
    // status bits
    // ------------------------------------------------------------
    // boot set wins over a clearing write in the same cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            enable_q <= 1'b0;
        end else if (boot_enable_set) begin
            enable_q <= 1'b1;
        end else if (wr_status_dbg) begin
            enable_q <= cmd_in.data[bdr_pkg::ST_ENABLE];
        end
    end

    // entry and exit store never act in one cycle: entry needs active clear, exit needs it set
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            active_q <= 1'b0;
        end else if (entry_ok) begin
            active_q <= 1'b1;
        end else if (exit_ok) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            clksel_q <= 1'b0;
        end else if (wr_status_dbg) begin
            clksel_q <= cmd_in.data[bdr_pkg::ST_CLKSEL];
        end
    end

    // tagging stops when debug is entered
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tag_q <= 1'b0;
        end else if (entry_ok) begin
            tag_q <= 1'b0;
        end else if (wr_status_dbg) begin
            tag_q <= cmd_in.data[bdr_pkg::ST_TAG];
        end
    end

    // shift-valid drops when debug is left
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sdv_q <= 1'b0;
        end else if (exit_ok) begin
            sdv_q <= 1'b0;
        end else if (wr_status_dbg) begin
            sdv_q <= cmd_in.data[bdr_pkg::ST_SDV];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            trace_q <= 1'b0;
        end else if (wr_status_dbg) begin
            trace_q <= cmd_in.data[bdr_pkg::ST_TRACE];
        end
    end

    // no command path may touch it; only a passing erase test sets it
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            unsecured_flag_q <= 1'b0;
        end else if (boot_unsecured_flag_set) begin
            unsecured_flag_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // condition-code hold
    // ------------------------------------------------------------
    bdr_ccr_hold u_ccr (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (wr_ccr),
        .wr_data_in  (cmd_in.data),
        .capture_in  (entry_ok),
        .core_ccr_in (core_ccr_in),
        .ccr_out     (ccr_hold_out)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        status_img = bdr_pkg::ZERO_BYTE;
        status_img[bdr_pkg::ST_ENABLE] = enable_q;
        status_img[bdr_pkg::ST_ACTIVE] = active_q;
        status_img[bdr_pkg::ST_TAG]    = tag_q;
        status_img[bdr_pkg::ST_SDV]    = sdv_q;
        status_img[bdr_pkg::ST_TRACE]  = trace_q;
        status_img[bdr_pkg::ST_CLKSEL] = clksel_q;
        status_img[bdr_pkg::ST_UNSECURED_FLAG]  = unsecured_flag_q;
    end

    always_comb begin
        position_img = bdr_pkg::ZERO_BYTE;
        position_img[bdr_pkg::POS_LSB +: bdr_pkg::POS_W] = reg_block_pos_in;
    end

    // unmapped offsets read zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= bdr_pkg::ZERO_BYTE;
        end else if (rd_cmd) begin
            unique case (cmd_in.addr)
                bdr_pkg::ADDR_STATUS:   rdata_q <= status_img;
                bdr_pkg::ADDR_CCR:      rdata_q <= ccr_hold_out;
                bdr_pkg::ADDR_POSITION: rdata_q <= position_img;
                default:                rdata_q <= bdr_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_cmd;
        end
    end

    assign rsp_out.valid = rvalid_q;
    assign rsp_out.data  = rdata_q;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign debug_enable_out       = enable_q;
    assign debug_active_out       = active_q;
    assign fw_table_map_out       = active_q;
    assign debug_clock_select_out = clksel_q;
    assign tag_enable_out         = tag_q;
    assign shift_data_valid_out   = sdv_q;
    assign trace_out              = trace_q;
    assign unsecured_flag_out     = unsecured_flag_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_refuse_disabled;
        entry_req_in && !enable_q && !active_q && !boot_enter_q |=> !active_q;
    endproperty
    a_refuse_disabled: assert property (p_refuse_disabled) else $error("went active while disabled");

    property p_active_set_cause;
        $rose(active_q) |-> $past(entry_try) && $past(enable_q);
    endproperty
    a_active_set_cause: assert property (p_active_set_cause) else $error("active set without entry");

    property p_map_follows;
        $rose(active_q) |-> fw_table_map_out ##1 fw_table_map_out || !active_q;
    endproperty
    a_map_follows: assert property (p_map_follows) else $error("firmware table not mapped");

    property p_exit_cause;
        $fell(active_q) |-> $past(wr_exit) && !fw_table_map_out;
    endproperty
    a_exit_cause: assert property (p_exit_cause) else $error("active cleared by other store");

    property p_clksel_cause;
        $changed(clksel_q) |-> $past(wr_status_dbg);
    endproperty
    a_clksel_cause: assert property (p_clksel_cause) else $error("clock select changed by illegal path");

    property p_status_read;
        rd_cmd && cmd_in.addr == bdr_pkg::ADDR_STATUS |=> rsp_out.valid && rsp_out.data == $past(status_img);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status readback wrong");

    // nested implication would pass vacuously on a lost write, so write and read are checked apart
    property p_ccr_write;
        wr_ccr |=> ccr_hold_out == $past(cmd_in.data);
    endproperty
    a_ccr_write: assert property (p_ccr_write) else $error("condition code hold lost write");

    property p_ccr_read;
        rd_cmd && cmd_in.addr == bdr_pkg::ADDR_CCR |=> rsp_out.valid && rsp_out.data == $past(ccr_hold_out);
    endproperty
    a_ccr_read: assert property (p_ccr_read) else $error("condition code hold readback wrong");

    property p_position_read;
        rd_cmd && cmd_in.addr == bdr_pkg::ADDR_POSITION |=>
            rsp_out.data[6:3] == $past(reg_block_pos_in) && rsp_out.data[7] == 1'b0 && rsp_out.data[2:0] == 3'h0;
    endproperty
    a_position_read: assert property (p_position_read) else $error("position readback wrong");

    property p_unsecured_flag_hold;
        unsecured_flag_q |=> unsecured_flag_q;
    endproperty
    a_unsecured_flag_hold: assert property (p_unsecured_flag_hold) else $error("unsecure cleared by a command");

endmodule : bdr_debug_regs

// [verification/bdr_host_model.sv]
// Purpose: host debug system that issues decoded debug read and write commands
// Assumes: commands launched at the falling edge, one per call
// Notes:   idle fields carry inverted values so a stale command never looks live

`timescale 1ns/100ps

module bdr_host_model (
    // clock
    input  wire logic              clk_in,
    // command and answer
    output bdr_pkg::bdr_cmd_t      cmd_out,
    input  wire bdr_pkg::bdr_rsp_t rsp_in
);
    initial cmd_out = '0;

    // ------------------------------------------------------------
    // one command, answer sampled at the falling edge right after the taking edge
    // ------------------------------------------------------------
    task automatic send(input logic wr, input bdr_pkg::bdr_src_t src, input logic [3:0] addr,
                        input logic [7:0] data, output logic [7:0] rdata, output logic rvalid);
        @(negedge clk_in);
        cmd_out <= {1'b1, wr, src, addr, data};
        @(negedge clk_in);
        rvalid = rsp_in.valid;
        rdata  = rsp_in.data;
        cmd_out <= {1'b0, 1'b0, bdr_pkg::SRC_OTHER, ~addr, ~data};
    endtask : send
endmodule : bdr_host_model

// [verification/bdr_debug_regs_tb.sv]
// Purpose: self-checking bench for the debug register set
// Assumes: inputs change at the falling edge only
// Notes:   flg packs enable,active,map,secure map,clksel,unsecured_flag,refused

`timescale 1ns/100ps

module bdr_debug_regs_tb;
    logic              clk_in       = 1'b0;
    logic              sys_rst_in   = 1'b1;
    logic              entry_req_in = 1'b0;
    logic              special      = 1'b0;
    logic              secured      = 1'b0;
    logic              erase_done   = 1'b0;
    logic              erase_ok     = 1'b0;
    logic [3:0]        pos          = 4'h0;
    logic [7:0]        core_ccr     = 8'h00;
    bdr_pkg::bdr_cmd_t cmd;
    bdr_pkg::bdr_rsp_t rsp;
    logic              refused, en, act, map, smap, clksel, tag, shift_data_valid, trc, unsecured_flag;
    logic [7:0]        ccr;
    logic [7:0]        flg;
    int                error_cnt = 0;
    int                cmp_count = 0;
    int                cyc_q     = 0;

    assign flg = {en, act, map, smap, clksel, unsecured_flag, refused, 1'b0};

    always #20 clk_in = ~clk_in;

    bdr_host_model u_host (.clk_in(clk_in), .cmd_out(cmd), .rsp_in(rsp));

    bdr_debug_regs u_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd), .rsp_out(rsp),
        .entry_req_in(entry_req_in), .entry_refused_out(refused),
        .special_single_chip_in(special), .secured_in(secured),
        .erase_done_in(erase_done), .erase_ok_in(erase_ok),
        .reg_block_pos_in(pos), .core_ccr_in(core_ccr),
        .debug_enable_out(en), .debug_active_out(act), .fw_table_map_out(map),
        .secure_table_map_out(smap), .debug_clock_select_out(clksel),
        .tag_enable_out(tag), .shift_data_valid_out(shift_data_valid), .trace_out(trc),
        .unsecured_flag_out(unsecured_flag), .ccr_hold_out(ccr)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input bdr_pkg::bdr_src_t src, input logic [3:0] addr, input logic [7:0] data);
        logic [7:0] rd_d;
        logic       rd_v;
        u_host.send(1'b1, src, addr, data, rd_d, rd_v);
    endtask : wr

    task automatic rd(input logic [3:0] addr, input logic [7:0] msk, input logic [7:0] exp);
        logic [7:0] rd_d;
        logic       rd_v;
        u_host.send(1'b0, bdr_pkg::SRC_HW, addr, 8'h00, rd_d, rd_v);
        chk({7'h00, rd_v}, 8'h01);
        chk(rd_d & msk, exp);
    endtask : rd

    // mode inputs settle with reset held, as the boot logic expects
    task automatic rst(input logic sp, input logic sec);
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        special    = sp;
        secured    = sec;
        erase_done = 1'b0;
        erase_ok   = 1'b0;
        repeat (12) @(negedge clk_in);
        sys_rst_in = 1'b0;
    endtask : rst

    // refused flag is combinational: look mid-cycle, then after the edge
    task automatic entry(input logic [7:0] exp_mid, input logic [7:0] exp_after);
        @(negedge clk_in);
        entry_req_in = 1'b1;
        #1;
        chk(flg, exp_mid);
        @(negedge clk_in);
        entry_req_in = 1'b0;
        #1;
        chk(flg, exp_after);
    endtask : entry

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_plain();
        rst(1'b0, 1'b0);
        rd(bdr_pkg::ADDR_STATUS, 8'hFF, 8'h00);
        rd(bdr_pkg::ADDR_CCR, 8'hFF, bdr_pkg::CCR_RST);
        entry(8'h02, 8'h00);
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_STATUS, 8'h80);
        rd(bdr_pkg::ADDR_STATUS, 8'hFF, 8'h80);
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_STATUS, 8'hC2);
        rd(bdr_pkg::ADDR_STATUS, 8'hFF, 8'h80);
        wr(bdr_pkg::SRC_OTHER, bdr_pkg::ADDR_STATUS, 8'h84);
        chk(flg, 8'h80);
        wr(bdr_pkg::SRC_FW, bdr_pkg::ADDR_STATUS, 8'h84);
        chk(flg, 8'h88);
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_STATUS, 8'h80);
        chk(flg, 8'h80);
        wr(bdr_pkg::SRC_HW, 4'h3, 8'hFF);
        rd(4'h3, 8'hFF, 8'h00);
    endtask : t_plain

    // entry, ignored second entry, refused clears, then the timed exit store
    task automatic t_entry_exit();
        core_ccr = 8'h5A;
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_STATUS, 8'hB8);
        chk({5'h00, tag, shift_data_valid, trc}, 8'h07);
        entry(8'h80, 8'hE0);
        chk(ccr, 8'h5A);
        chk({5'h00, tag, shift_data_valid, trc}, 8'h03);
        entry(8'hE0, 8'hE0);
        wr(bdr_pkg::SRC_OTHER, bdr_pkg::ADDR_STATUS, 8'h80);
        chk(flg, 8'hE0);
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_STATUS, 8'h98);
        chk(flg, 8'hE0);
        wr(bdr_pkg::SRC_FW_EXIT, bdr_pkg::ADDR_STATUS, 8'h00);
        chk(flg, 8'h80);
        chk({5'h00, tag, shift_data_valid, trc}, 8'h01);
    endtask : t_entry_exit

    task automatic t_ccr_pos();
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_CCR, 8'hA5);
        rd(bdr_pkg::ADDR_CCR, 8'hFF, 8'hA5);
        wr(bdr_pkg::SRC_FW, bdr_pkg::ADDR_CCR, 8'h5A);
        rd(bdr_pkg::ADDR_CCR, 8'hFF, 8'h5A);
        wr(bdr_pkg::SRC_OTHER, bdr_pkg::ADDR_CCR, 8'hFF);
        rd(bdr_pkg::ADDR_CCR, 8'hFF, 8'h5A);
        pos = 4'hB;
        rd(bdr_pkg::ADDR_POSITION, 8'hFF, 8'h58);
        wr(bdr_pkg::SRC_HW, bdr_pkg::ADDR_POSITION, 8'hFF);
        pos = 4'h4;
        rd(bdr_pkg::ADDR_POSITION, 8'hFF, 8'h20);
    endtask : t_ccr_pos

    task automatic t_boot();
        rst(1'b1, 1'b0);
        repeat (4) @(negedge clk_in);
        chk(flg, 8'hE0);
        rd(bdr_pkg::ADDR_STATUS, 8'h82, 8'h80);
        rst(1'b1, 1'b1);
        repeat (6) @(negedge clk_in);
        chk(flg & 8'hFD, 8'h10);
        erase_done = 1'b1;
        erase_ok   = 1'b1;
        repeat (3) @(negedge clk_in);
        chk(flg, 8'hE4);
        rd(bdr_pkg::ADDR_STATUS, 8'h82, 8'h82);
        rst(1'b1, 1'b1);
        erase_done = 1'b1;
        repeat (4) @(negedge clk_in);
        chk(flg & 8'hFD, 8'h00);
        rd(bdr_pkg::ADDR_STATUS, 8'h82, 8'h00);
    endtask : t_boot

    always @(posedge clk_in) begin
        cyc_q <= cyc_q + 1;
        if (cyc_q == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        t_plain();
        t_entry_exit();
        t_ccr_pos();
        t_boot();
        give_verdict();
    end
endmodule : bdr_debug_regs_tb
